// ===== dv/mbs_core_model.sv
// Motion core stand-in: finishes blocks, chains to the next, brakes.
// Assumes the sequencer drives move_en and act_block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module mbs_core_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       move_en,
  input  wire logic [7:0] act_block,
  input  wire logic [7:0] last_block,
  input  wire logic [7:0] end_code,
  output logic            blk_done,
  output logic [7:0]      blk_next,
  output logic            speed_zero
);
  logic [3:0] run_q;
  logic [2:0] spd_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 4'h0;
      spd_q <= 3'h0;
    end else begin
      run_q <= move_en ? ((run_q == 4'h6) ? 4'h0 : run_q + 4'h1) : run_q;
      spd_q <= move_en ? 3'h4 : ((spd_q != 3'h0) ? spd_q - 3'h1 : 3'h0);
    end
  end
  // Block lasts seven moving cycles; chain ends at last_block
  assign blk_done   = (run_q == 4'h6);
  assign blk_next   = (act_block == last_block) ? end_code : act_block + 8'h01;
  assign speed_zero = (spd_q == 3'h0);
endmodule
`default_nettype wire

// ===== dv/mbs_sequencer_tb.sv
// Testbench of the motion block sequencer: scripted and random commands.
// Assumes mbs_core_model answers for the motion core.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module mbs_sequencer_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rst_p = 1'b0;
  logic [15:0] cmd = 16'h0000;
  logic [7:0]  last_blk = 8'h01;
  logic [7:0]  end_code = 8'h00;
  logic [31:0] seed = 32'h75F8827B;
  logic [5:0]  rnd = 6'h00;
  logic [5:0]  rnd_p;
  logic [4:0]  sel;
  logic [15:0] rpt;
  logic [7:0]  nxt, act, act_p, res, exp_b;
  logic        done, spd0, mv, mv_p, stp, hlt_p, spd_p;
  logic [7:0]  exp_q[$];
  logic [7:0]  ends[4] = '{mbs_pkg::NEXT_END, mbs_pkg::NEXT_ERR_STOP,
                           mbs_pkg::NEXT_STOP_ERR, mbs_pkg::NEXT_EMERG_ERR};
  int          n_mismatch = 0;
  int          n_tests = 0;

  mbs_sequencer u_dut (
    .CLK(clk), .RESET_N(rst_n), .CMD_WORD(cmd), .BLK_TYPE(rnd[1:0]),
    .BLK_NEXT(nxt), .BLK_DONE(done), .IN_WINDOW(rnd[2]), .SPEED_ZERO(spd0),
    .GEAR_USED(rnd[3]), .GEAR_COUPLED(rnd[4]), .FOLLOW_ERR(rnd[5]),
    .REPORT_WORD(rpt), .ACT_BLOCK(act), .RESUMABLE_BLOCK_INDICATOR(res),
    .MOVE_EN(mv), .RAMP_STOP(stp));
  mbs_core_model u_core (
    .clk(clk), .reset_n(rst_n), .move_en(mv), .act_block(act),
    .last_block(last_blk), .end_code(end_code), .blk_done(done),
    .blk_next(nxt), .speed_zero(spd0));

  always #4 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(posedge clk) begin
    #1 seed = lfsr(seed);
    rnd = seed[5:0];
  end

  // Scoreboard: block starts against notes, status bits against inputs
  always @(posedge clk) begin
    if (rst_n && mv && (!mv_p || act !== act_p)) begin
      exp_b = exp_q.pop_front();
      `CHK("active block", exp_b, act)
      `CHK("busy", 1'b1, rpt[8])
    end
    if (rst_n && rst_p) begin
      `CHK("target", hlt_p ? spd_p : (rnd_p[2] && rnd_p[1:0] < 2'h2), rpt[10])
      `CHK("gear", rnd_p[3] && rnd_p[4], rpt[12])
      `CHK("follow", rnd_p[5], rpt[13])
    end
    rst_p <= rst_n;
    mv_p  <= mv;
    act_p <= act;
    rnd_p <= rnd;
    hlt_p <= cmd[8];
    spd_p <= spd0;
  end

  task automatic put(input logic [15:0] w);
    @(posedge clk);
    #1 cmd = w;
  endtask

  task automatic go(input logic [4:0] s, input logic [8:0] low, input logic [7:0] e);
    exp_q.push_back(e);
    put({s, 2'b01, low});
  endtask

  task automatic fin();
    for (int i = 0; i < 20 && rpt[8] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("busy start", 1'b1, rpt[8])
    for (int i = 0; i < 300 && rpt[8] !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("busy end", 1'b0, rpt[8])
    `CHK("resume none", 8'hFF, res)
    put(16'h000F);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #160000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("resume reset", 8'hFF, res)
    for (int k = 0; k < 5; k++) begin
      sel = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : (k == 2) ? 5'h10 : seed[10:6];
      go(sel, 9'h00F, {3'h0, sel} + 8'h01);
      fin();
    end
    for (int k = 0; k < 4; k++) begin
      end_code = ends[k];
      last_blk = 8'(4 * k + 3);
      go(5'(4 * k), 9'h01F, 8'(4 * k + 1));
      exp_q.push_back(8'(4 * k + 2));
      exp_q.push_back(8'(4 * k + 3));
      fin();
    end
    // Drop run mid block, then resume it and resume with none left
    go(5'h06, 9'h00F, 8'h07);
    repeat (3) @(posedge clk);
    put(16'h000F);
    @(posedge clk);
    #1;
    `CHK("ramp stop", 1'b1, stp)
    `CHK("resume block", 8'h07, res)
    for (int i = 0; i < 50 && stp !== 1'b0; i++) @(posedge clk);
    go(5'h00, 9'h04F, 8'h07);
    fin();
    go(5'h03, 9'h04F, 8'h04);
    fin();
    // Halt mid block, then release it
    go(5'h09, 9'h00F, 8'h0A);
    repeat (2) @(posedge clk);
    put(16'h4B0F);
    repeat (8) @(posedge clk);
    #1;
    `CHK("halt move", 1'b0, mv)
    `CHK("halt ramp", 1'b1, stp)
    exp_q.push_back(8'h0A);
    put(16'h4A0F);
    fin();
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== src/mbs_edge.sv
// Rising edge detector for one level input.
// Input is synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module mbs_edge (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      rise
);
  typedef struct packed {
    logic prev;
  } mbs_edge_type;
  mbs_edge_type st_q;
  mbs_edge_type st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = level;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = level & ~st_q.prev;
endmodule
`default_nettype wire

// ===== src/mbs_pkg.sv
// Package of the motion block sequencer: command and report word layout, codes.
// Assumes a single 125 MHz control clock; no timing counts are needed.
package mbs_pkg;
  // ==========================================================================
  // Command word fields
  localparam int CMD_SEQ_BIT    = 4;
  localparam int CMD_RESUME_BIT = 6;
  localparam int CMD_HALT_BIT   = 8;
  localparam int CMD_RUN_BIT    = 9;
  localparam int CMD_SEL_LSB    = 11;
  localparam int CMD_SEL_MSB    = 15;
  // ==========================================================================
  // Report word fields
  localparam int RPT_BUSY_BIT   = 8;
  localparam int RPT_TARGET_BIT = 10;
  localparam int RPT_GEAR_BIT   = 12;
  localparam int RPT_FOLLOW_BIT = 13;
  // ==========================================================================
  // Block numbers and next-block codes
  localparam int           BLK_W          = 8;
  localparam logic [7:0]   BLK_ONE        = 8'h01;
  localparam logic [7:0]   NEXT_END       = 8'h00;
  localparam logic [7:0]   NEXT_ERR_STOP  = 8'hFF;
  localparam logic [7:0]   NEXT_STOP_ERR  = 8'hFE;
  localparam logic [7:0]   NEXT_EMERG_ERR = 8'hFD;
  localparam logic [7:0]   RESUME_NONE    = 8'hFF;
  localparam logic [15:0]  WORD_RESET     = 16'h0000;
  // Block types
  localparam logic [1:0]   TYPE_ABS       = 2'h0;
  localparam logic [1:0]   TYPE_REL       = 2'h1;
  localparam logic [1:0]   TYPE_OTHER     = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} mbs_state_type;
endpackage

// ===== src/mbs_sequencer.sv
// Motion block sequencer: command word in, report word and indicators out.
// Assumes the motion core reports block type, completion, stop and gear status.
//
// Behaviour
// - Start block is select field bits 15..11 plus one.
// - Command bit 4 chooses single block or automatic chain.
// - Block number is latched only on run bit rising edge.
// - Report bit 8 stays high while a block or chain runs.
// - Single mode clears report bit 8 when the block completes.
// - Chain mode clears bit 8 at next code 0, -1, -2 or -3.
// - Actual block indicator tracks the block being executed.
// - Run bit cleared mid-run decelerates with the active block ramp.
// - Resume plus run edge continues from the interrupted block.
// - Resume without valid block falls back to select-field block.
// - Resume indicator reads -1 unless a block was interrupted.
// - Halt clear: bit 10 high only for positioning blocks in window.
// - Command bit 8 stops the block with its ramp, stays enabled.
// - Halt set: bit 10 low while decelerating, high at zero speed.
// - Clearing halt continues the halted block.
// - Report bit 12 high only while gear used and coupled.
// - Run bit must stay high; dropping it interrupts positioning.
// - Resume bit set starts from the last interrupted block.
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [15:0] CMD_WORD,
  input  wire logic [1:0]  BLK_TYPE,
  input  wire logic [7:0]  BLK_NEXT,
  input  wire logic        BLK_DONE,
  input  wire logic        IN_WINDOW,
  input  wire logic        SPEED_ZERO,
  input  wire logic        GEAR_USED,
  input  wire logic        GEAR_COUPLED,
  input  wire logic        FOLLOW_ERR,
  output logic [15:0]      REPORT_WORD,
  output logic [7:0]       ACT_BLOCK,
  output logic [7:0]       RESUMABLE_BLOCK_INDICATOR,
  output logic             MOVE_EN,
  output logic             RAMP_STOP
);
  typedef struct packed {
    mbs_pkg::mbs_state_type fsm;
    logic                   auto_mode;
    logic [7:0]             act;
    logic [7:0]             resume;
    logic [15:0]            rpt;
    logic                   move;
    logic                   ramp;
  } mbs_st_type;

  mbs_st_type st_q;
  mbs_st_type st_d;
  logic       run_rise;
  logic       run_lvl;
  logic       halt;
  logic [7:0] sel_blk;

  // Next-block code that ends a chain
  function automatic logic is_end(input logic [7:0] code);
    is_end = (code == mbs_pkg::NEXT_END) || (code == mbs_pkg::NEXT_ERR_STOP) ||
             (code == mbs_pkg::NEXT_STOP_ERR) || (code == mbs_pkg::NEXT_EMERG_ERR);
  endfunction

  // Positive block numbers only count as block references
  function automatic logic is_block(input logic [7:0] code);
    is_block = !code[7] && (code != mbs_pkg::NEXT_END);
  endfunction

  assign run_lvl = CMD_WORD[mbs_pkg::CMD_RUN_BIT];
  assign halt    = CMD_WORD[mbs_pkg::CMD_HALT_BIT];
  assign sel_blk = {3'h0, CMD_WORD[mbs_pkg::CMD_SEL_MSB:mbs_pkg::CMD_SEL_LSB]}
                   + mbs_pkg::BLK_ONE;

  mbs_edge u_run_edge (
    .clk     (CLK),
    .reset_n (RESET_N),
    .level   (run_lvl),
    .rise    (run_rise)
  );

  // ==========================================================================
  // Sequencing
  always_comb begin
    st_d = st_q;
    case (st_q.fsm)
      mbs_pkg::ST_IDLE: begin
        st_d.move = 1'b0;
        if (run_rise) begin
          st_d.auto_mode = CMD_WORD[mbs_pkg::CMD_SEQ_BIT];
          if (CMD_WORD[mbs_pkg::CMD_RESUME_BIT] &&
              st_q.resume != mbs_pkg::RESUME_NONE) begin
            st_d.act = st_q.resume;
          end else begin
            st_d.act = sel_blk;
          end
          st_d.resume = mbs_pkg::RESUME_NONE;
          st_d.fsm    = mbs_pkg::ST_RUN;
          st_d.move   = 1'b1;
          st_d.ramp   = 1'b0;
        end
      end
      mbs_pkg::ST_RUN: begin
        if (!run_lvl) begin
          st_d.resume = st_q.act;
          st_d.ramp   = 1'b1;
          st_d.move   = 1'b0;
          st_d.fsm    = mbs_pkg::ST_STOP;
        end else if (halt) begin
          st_d.ramp = 1'b1;
          st_d.move = 1'b0;
        end else begin
          st_d.ramp = 1'b0;
          st_d.move = 1'b1;
          if (BLK_DONE) begin
            if (!st_q.auto_mode || is_end(BLK_NEXT)) begin
              st_d.fsm  = mbs_pkg::ST_IDLE;
              st_d.move = 1'b0;
            end else if (is_block(BLK_NEXT)) begin
              st_d.act = BLK_NEXT;
            end else begin
              st_d.fsm  = mbs_pkg::ST_IDLE;
              st_d.move = 1'b0;
            end
          end
        end
      end
      mbs_pkg::ST_STOP: begin
        if (SPEED_ZERO) begin
          st_d.ramp = 1'b0;
          st_d.fsm  = mbs_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d.fsm = mbs_pkg::ST_IDLE;
      end
    endcase

    // ========================================================================
    // Report word
    st_d.rpt = mbs_pkg::WORD_RESET;
    st_d.rpt[mbs_pkg::RPT_BUSY_BIT] = (st_d.fsm != mbs_pkg::ST_IDLE);
    if (halt) begin
      st_d.rpt[mbs_pkg::RPT_TARGET_BIT] = SPEED_ZERO;
    end else begin
      st_d.rpt[mbs_pkg::RPT_TARGET_BIT] = IN_WINDOW &&
        (BLK_TYPE == mbs_pkg::TYPE_ABS || BLK_TYPE == mbs_pkg::TYPE_REL);
    end
    st_d.rpt[mbs_pkg::RPT_GEAR_BIT]   = GEAR_USED && GEAR_COUPLED;
    st_d.rpt[mbs_pkg::RPT_FOLLOW_BIT] = FOLLOW_ERR;
    // Bits 3..0, 5, 7 and 10 of the command word are not used here
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q.fsm       <= mbs_pkg::ST_IDLE;
      st_q.auto_mode <= 1'b0;
      st_q.act       <= mbs_pkg::BLK_ONE;
      st_q.resume    <= mbs_pkg::RESUME_NONE;
      st_q.rpt       <= mbs_pkg::WORD_RESET;
      st_q.move      <= 1'b0;
      st_q.ramp      <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign REPORT_WORD               = st_q.rpt;
  assign ACT_BLOCK                 = st_q.act;
  assign RESUMABLE_BLOCK_INDICATOR = st_q.resume;
  assign MOVE_EN                   = st_q.move;
  assign RAMP_STOP                 = st_q.ramp;

  // ==========================================================================
  // Checks: start and resume
  AST_START_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && run_rise && !CMD_WORD[mbs_pkg::CMD_RESUME_BIT])
    |=> ACT_BLOCK == $past(sel_blk)) else $error("start block wrong");

  AST_MODE: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && run_rise)
    |=> st_q.auto_mode == $past(CMD_WORD[mbs_pkg::CMD_SEQ_BIT])) else $error("mode");

  AST_BUSY: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && run_rise) |=> REPORT_WORD[mbs_pkg::RPT_BUSY_BIT])
    else $error("busy not set");

  AST_RESUME_START: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && run_rise && CMD_WORD[mbs_pkg::CMD_RESUME_BIT] &&
     st_q.resume != mbs_pkg::RESUME_NONE)
    |=> ACT_BLOCK == $past(st_q.resume)) else $error("resume block wrong");

  AST_RESUME_FALLBACK: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && run_rise && CMD_WORD[mbs_pkg::CMD_RESUME_BIT] &&
     st_q.resume == mbs_pkg::RESUME_NONE)
    |=> ACT_BLOCK == $past(sel_blk)) else $error("fallback block wrong");

  AST_RESUME_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && run_rise)
    |=> RESUMABLE_BLOCK_INDICATOR == mbs_pkg::RESUME_NONE) else $error("resume not cleared");

  AST_NO_RESTART: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_STOP && run_rise)
    |=> st_q.fsm != mbs_pkg::ST_RUN && ACT_BLOCK == $past(ACT_BLOCK))
    else $error("restart while stopping");

  AST_IDLE_STILL: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_IDLE && !run_rise)
    |=> !REPORT_WORD[mbs_pkg::RPT_BUSY_BIT] && !MOVE_EN)
    else $error("busy while idle");

  // ==========================================================================
  // Checks: block completion and chaining
  AST_SINGLE_DONE: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && !st_q.auto_mode && run_lvl && !halt && BLK_DONE)
    |=> !REPORT_WORD[mbs_pkg::RPT_BUSY_BIT]) else $error("single not cleared");

  AST_CHAIN_END: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && run_lvl && !halt && BLK_DONE && is_end(BLK_NEXT))
    |=> st_q.fsm == mbs_pkg::ST_IDLE) else $error("chain end");

  AST_CHAIN_NEXT: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && st_q.auto_mode && run_lvl && !halt && BLK_DONE &&
     is_block(BLK_NEXT)) |=> ACT_BLOCK == $past(BLK_NEXT)) else $error("act");

  AST_CHAIN_BUSY: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && st_q.auto_mode && run_lvl && !halt && BLK_DONE &&
     is_block(BLK_NEXT))
    |=> REPORT_WORD[mbs_pkg::RPT_BUSY_BIT] && MOVE_EN) else $error("chain busy dropped");

  // ==========================================================================
  // Checks: interrupt and halt
  AST_INTERRUPT: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && !run_lvl)
    |=> RAMP_STOP && !MOVE_EN && RESUMABLE_BLOCK_INDICATOR == $past(ACT_BLOCK))
    else $error("interrupt");

  AST_STOP_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_STOP && !SPEED_ZERO) |=> RAMP_STOP && !MOVE_EN)
    else $error("ramp released early");

  AST_STOP_END: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_STOP && SPEED_ZERO) |=> !RAMP_STOP && !MOVE_EN)
    else $error("stop not ended");

  AST_HALT: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && run_lvl && halt) |=> RAMP_STOP && !MOVE_EN)
    else $error("halt");

  AST_HALT_RELEASE: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && run_lvl && !halt && !BLK_DONE)
    |=> MOVE_EN && !RAMP_STOP && ACT_BLOCK == $past(ACT_BLOCK))
    else $error("halted block not continued");

  AST_HALT_KEEP: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q.fsm == mbs_pkg::ST_RUN && run_lvl && halt)
    |=> REPORT_WORD[mbs_pkg::RPT_BUSY_BIT] && ACT_BLOCK == $past(ACT_BLOCK))
    else $error("halt lost block");

  // ==========================================================================
  // Checks: report word
  AST_TARGET_HALT: assert property (@(posedge CLK) disable iff (!RESET_N)
    halt |=> REPORT_WORD[mbs_pkg::RPT_TARGET_BIT] == $past(SPEED_ZERO))
    else $error("target halt");

  AST_TARGET_MOVE: assert property (@(posedge CLK) disable iff (!RESET_N)
    !halt |=> REPORT_WORD[mbs_pkg::RPT_TARGET_BIT] == $past(IN_WINDOW &&
      (BLK_TYPE == mbs_pkg::TYPE_ABS || BLK_TYPE == mbs_pkg::TYPE_REL)))
    else $error("target window");

  AST_GEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
    1'b1 |=> REPORT_WORD[mbs_pkg::RPT_GEAR_BIT] == $past(GEAR_USED && GEAR_COUPLED))
    else $error("gear");

  AST_FOLLOW: assert property (@(posedge CLK) disable iff (!RESET_N)
    1'b1 |=> REPORT_WORD[mbs_pkg::RPT_FOLLOW_BIT] == $past(FOLLOW_ERR))
    else $error("following error");

  // Report bits not owned here read zero
  localparam logic [15:0] rpt_used = (16'h0001 << mbs_pkg::RPT_BUSY_BIT) |
    (16'h0001 << mbs_pkg::RPT_TARGET_BIT) | (16'h0001 << mbs_pkg::RPT_GEAR_BIT) |
    (16'h0001 << mbs_pkg::RPT_FOLLOW_BIT);
  AST_SPARE_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
    (REPORT_WORD & ~rpt_used) == mbs_pkg::WORD_RESET) else $error("spare bits set");

  // ==========================================================================
  // Scenario covers
  COV_SINGLE: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_q.fsm == mbs_pkg::ST_RUN && !st_q.auto_mode ##[1:20] st_q.fsm == mbs_pkg::ST_IDLE);

  COV_CHAIN: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_q.fsm == mbs_pkg::ST_RUN && st_q.auto_mode && BLK_DONE && is_block(BLK_NEXT));

  COV_RESUME: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_q.fsm == mbs_pkg::ST_STOP ##[1:20] run_rise && CMD_WORD[mbs_pkg::CMD_RESUME_BIT]);

  COV_HALT: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_q.fsm == mbs_pkg::ST_RUN && halt ##[1:20] st_q.fsm == mbs_pkg::ST_RUN && !halt);
endmodule
`default_nettype wire
